/* File: logic/sle_top.sv */
// smoke level evaluator: decision filter, week averaging, service and alarm triggers
// assumes a classic wishbone master and samples arriving synchronous to clk_i
//
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
module sle_top #(
  parameter int N_DET = 8,
  parameter int DIW = 3,
  parameter int SEC_CYC = sle_pkg::SEC_CYC,
  parameter int STARTUP_S = sle_pkg::STARTUP_S,
  parameter int HOUR_S = sle_pkg::HOUR_S,
  parameter int WEEK_H = sle_pkg::WEEK_H
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic smp_valid_i,
  input wire logic [DIW-1:0] smp_det_i,
  input wire logic [sle_pkg::VAL_W-1:0] smp_val_i,
  output logic [N_DET-1:0] prewarn_o,
  output logic [N_DET-1:0] fire_o,
  output logic [N_DET-1:0] heavy_o,
  output logic [N_DET-1:0] service_o,
  output logic startup_done_o
);
  import sle_pkg::*;

  // ==========================================
  // state
  logic [7:0] cur_r [N_DET];
  logic [7:0] dec_r [N_DET];
  logic [7:0] avg_r [N_DET];
  logic [N_DET-1:0] pw_r, fa_r, hs_r, svc_r;
  logic pw_en_r;
  logic [7:0] step_r, fa_off_r, pw_off_r, hs_off_r;
  logic [DIW-1:0] sel_r;
  logic ack_r;
  logic [31:0] rdat_r;
  logic repl;
  logic [DIW-1:0] repl_idx;
  logic [31:0] sec_cnt_r;
  logic sec_tick;
  logic [15:0] hsec_cnt_r;
  logic [15:0] start_cnt_r;
  logic start_done_r, start_pend_r, hour_pend_r;
  sle_sweep_t st_r;
  logic [DIW-1:0] idx_r;
  logic add_hr_r, do_avg_r, was_start_r;
  logic [7:0] hrs_r;
  logic [15:0] mem_rd;
  logic [15:0] sum_new;
  logic [7:0] cnt;
  logic [7:0] avg_calc;
  logic [15:0] quot;
  logic mem_we;
  logic smp_ok;

  // ==========================================
  // wishbone slave
  logic acc, wr_acc;
  assign acc = wb_cyc_i & wb_stb_i & ~ack_r;
  // writes land on the edge that samples ack high
  assign wr_acc = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
  assign repl = wr_acc & (wb_adr_i == REG_REPLACE) & wb_sel_i[0];
  assign repl_idx = wb_dat_i[DIW-1:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= acc;
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pw_en_r <= PW_EN_RST;
      step_r <= STEP_RST;
      fa_off_r <= FA_OFF_RST;
      pw_off_r <= PW_OFF_RST;
      hs_off_r <= HS_OFF_RST;
      sel_r <= '0;
    end else if (wr_acc) begin
      case (wb_adr_i)
        REG_CTRL: begin
          if (wb_sel_i[0]) begin
            pw_en_r <= wb_dat_i[CTRL_PW_EN_BIT];
          end
          if (wb_sel_i[1]) begin
            step_r <= wb_dat_i[CTRL_STEP_LSB +: 8];
          end
        end
        REG_FA_OFF: begin
          if (wb_sel_i[0]) begin
            fa_off_r <= wb_dat_i[7:0];
          end
        end
        REG_PW_OFF: begin
          if (wb_sel_i[0]) begin
            pw_off_r <= wb_dat_i[7:0];
          end
        end
        REG_HS_OFF: begin
          if (wb_sel_i[0]) begin
            hs_off_r <= wb_dat_i[7:0];
          end
        end
        REG_SEL: begin
          if (wb_sel_i[0]) begin
            sel_r <= wb_dat_i[DIW-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // levels of one detector, in 0.1 %/m
  function automatic logic [8:0] lvl(input logic [7:0] a, input logic [7:0] off);
    lvl = {1'b0, a} + {1'b0, off};
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_r <= '0;
    end else if (acc) begin
      case (wb_adr_i)
        REG_CTRL: rdat_r <= {16'h0000, step_r, 7'h00, pw_en_r};
        REG_FA_OFF: rdat_r <= {24'h000000, fa_off_r};
        REG_PW_OFF: rdat_r <= {24'h000000, pw_off_r};
        REG_HS_OFF: rdat_r <= {24'h000000, hs_off_r};
        REG_STATUS: rdat_r <= {30'h00000000, st_r != SW_IDLE, start_done_r};
        REG_SEL: rdat_r <= {{(32-DIW){1'b0}}, sel_r};
        REG_DET_INFO: begin
          rdat_r <= {4'h0, svc_r[sel_r], hs_r[sel_r], fa_r[sel_r], pw_r[sel_r],
                     avg_r[sel_r], dec_r[sel_r], cur_r[sel_r]};
        end
        REG_DET_LVL: begin
          rdat_r <= {5'h00, lvl(avg_r[sel_r], hs_off_r), lvl(avg_r[sel_r], fa_off_r),
                     lvl(avg_r[sel_r], pw_off_r)};
        end
        default: rdat_r <= '0;
      endcase
    end
  end

  // ==========================================
  // time base: seconds, startup, hours
  assign sec_tick = sec_cnt_r == 32'(SEC_CYC - 1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sec_cnt_r <= '0;
    end else if (sec_tick) begin
      sec_cnt_r <= '0;
    end else begin
      sec_cnt_r <= sec_cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_cnt_r <= '0;
      start_pend_r <= 1'b0;
    end else begin
      if (sec_tick && !start_done_r && start_cnt_r != 16'(STARTUP_S)) begin
        start_cnt_r <= start_cnt_r + 16'h0001;
      end
      if (st_r == SW_IDLE && start_pend_r) begin
        start_pend_r <= 1'b0;
      end
      if (sec_tick && start_cnt_r == 16'(STARTUP_S - 1)) begin
        start_pend_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hsec_cnt_r <= '0;
      hour_pend_r <= 1'b0;
    end else begin
      if (sec_tick && start_done_r) begin
        hsec_cnt_r <= (hsec_cnt_r == 16'(HOUR_S - 1)) ? 16'h0000 : hsec_cnt_r + 16'h0001;
      end
      if (st_r == SW_IDLE && !start_pend_r && hour_pend_r) begin
        hour_pend_r <= 1'b0;
      end
      if (sec_tick && start_done_r && hsec_cnt_r == 16'(HOUR_S - 1)) begin
        hour_pend_r <= 1'b1;
      end
    end
  end

  // ==========================================
  // averaging sweep over all detectors
  sle_mem #(.W(16), .DEPTH(N_DET), .AW(DIW)) u_mem (
    .clk_i(clk_i),
    .rd_en_i(st_r == SW_RD),
    .rd_addr_i(idx_r),
    .rd_data_o(mem_rd),
    .we_i(mem_we),
    .wr_addr_i(idx_r),
    .wr_data_i(do_avg_r ? 16'h0000 : sum_new)
  );

  assign mem_we = st_r == SW_UPD;
  assign sum_new = mem_rd + (add_hr_r ? {8'h00, cur_r[idx_r]} : 16'h0000);
  assign cnt = hrs_r + {7'h00, add_hr_r};
  assign quot = (cnt == 8'h00) ? {8'h00, cur_r[idx_r]} : sum_new / {8'h00, cnt};
  assign avg_calc = (quot > 16'h00ff) ? 8'hff : quot[7:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= SW_IDLE;
      idx_r <= '0;
      add_hr_r <= 1'b0;
      do_avg_r <= 1'b0;
      was_start_r <= 1'b0;
      hrs_r <= '0;
      start_done_r <= 1'b0;
    end else begin
      case (st_r)
        SW_IDLE: begin
          idx_r <= '0;
          if (start_pend_r) begin
            add_hr_r <= 1'b0;
            do_avg_r <= 1'b1;
            was_start_r <= 1'b1;
            st_r <= SW_RD;
          end else if (hour_pend_r) begin
            add_hr_r <= 1'b1;
            do_avg_r <= (hrs_r + 8'h01) >= 8'(WEEK_H);
            was_start_r <= 1'b0;
            st_r <= SW_RD;
          end
        end
        SW_RD: st_r <= SW_UPD;
        SW_UPD: begin
          if (idx_r == DIW'(N_DET - 1)) begin
            st_r <= SW_IDLE;
            hrs_r <= do_avg_r ? 8'h00 : cnt;
            if (was_start_r) begin
              start_done_r <= 1'b1;
            end
          end else begin
            idx_r <= idx_r + DIW'(1);
            st_r <= SW_RD;
          end
        end
        default: st_r <= SW_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < N_DET; i++) begin
        avg_r[i] <= SENS_DEFAULT;
      end
    end else begin
      if (st_r == SW_UPD && do_avg_r) begin
        if (svc_r[idx_r] || avg_calc >= SERVICE_LVL) begin
          avg_r[idx_r] <= SERVICE_LVL;
        end else begin
          avg_r[idx_r] <= avg_calc;
        end
      end
      if (repl) begin
        avg_r[repl_idx] <= SENS_DEFAULT;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      svc_r <= '0;
    end else begin
      if (repl) begin
        svc_r[repl_idx] <= 1'b0;
      end
      if (st_r == SW_UPD && do_avg_r && avg_calc >= SERVICE_LVL) begin
        svc_r[idx_r] <= 1'b1;
      end
    end
  end

  // ==========================================
  // sample filter and classification
  sle_filt_if fif ();
  sle_filt u_filt (.f(fif));

  assign fif.smp = smp_val_i;
  assign fif.dec = dec_r[smp_det_i];
  assign fif.step = step_r;
  assign fif.pw_lvl = lvl(avg_r[smp_det_i], pw_off_r);
  assign fif.fa_lvl = lvl(avg_r[smp_det_i], fa_off_r);
  assign fif.hs_lvl = lvl(avg_r[smp_det_i], hs_off_r);
  assign smp_ok = smp_valid_i && (32'(smp_det_i) < 32'(N_DET));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < N_DET; i++) begin
        cur_r[i] <= SENS_DEFAULT;
        dec_r[i] <= 8'h00;
      end
    end else begin
      if (smp_ok) begin
        cur_r[smp_det_i] <= smp_val_i;
        dec_r[smp_det_i] <= fif.dec_nxt;
      end
      if (repl) begin
        cur_r[repl_idx] <= SENS_DEFAULT;
        dec_r[repl_idx] <= 8'h00;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pw_r <= '0;
      fa_r <= '0;
      hs_r <= '0;
    end else begin
      if (smp_ok) begin
        pw_r[smp_det_i] <= pw_en_r & fif.pw_hit;
        fa_r[smp_det_i] <= start_done_r & fif.fa_hit;
        hs_r[smp_det_i] <= start_done_r & fif.hs_hit;
      end
      if (repl) begin
        pw_r[repl_idx] <= 1'b0;
        fa_r[repl_idx] <= 1'b0;
        hs_r[repl_idx] <= 1'b0;
      end
    end
  end

  // ==========================================
  // trigger outputs
  assign prewarn_o = pw_r;
  assign fire_o = fa_r;
  assign heavy_o = hs_r;
  assign service_o = svc_r;
  assign startup_done_o = start_done_r;
endmodule // sle_top

/* File: inc/sle_pkg.sv */
// constants shared by the smoke level evaluator design files
// assumes a 20 MHz clock; one sensor lsb is 0.1 %/m obscuration
// Operation
// - every detector gets one sensor value stored each hour and a week average once a week.
// - after reset each current sensor value and week average start at 0.1 %/m.
// - the fire alarm level is the week average plus the fire alarm offset, refreshed with it.
// - a week average reaching 1.8 %/m raises service and is held there until replacement.
// - after any restart the first week average is produced within two and a half minutes.
// - until that first average exists all smoke detector fire alarms are suppressed.
// - the state is classified from the filtered decision value, not the raw sample.
// - pre-warning, when enabled, uses a smaller offset so it comes before fire alarm.
// - heavy smoke uses a larger offset so it comes after fire alarm.
// - pre-warning, fire alarm and heavy smoke are separate output triggers.
// - sensor values and derived levels are all in units of 0.1 %/m.
// - the decision value starts at zero and copies a sample within one step of it.
// - a sample further than one step away moves the decision value by exactly one step.
// - pre-warning follows the decision value, clearing itself when it drops below the level.
package sle_pkg;
  // ==========================================
  // values, 0.1 %/m per lsb
  localparam int VAL_W = 8;
  localparam int LVL_W = 9;
  localparam logic [7:0] SENS_DEFAULT = 8'h01;
  localparam logic [7:0] SERVICE_LVL = 8'h12;
  localparam logic [7:0] FA_OFF_RST = 8'h1e;
  localparam logic [7:0] PW_OFF_RST = 8'h16;
  localparam logic [7:0] HS_OFF_RST = 8'h32;
  localparam logic [7:0] STEP_RST = 8'h0a;
  localparam logic PW_EN_RST = 1'b1;
  // ==========================================
  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_S = 1;
  localparam int SEC_CYC = CLK_HZ * TICK_S;
  localparam int STARTUP_MIN_X10 = 25;
  localparam int STARTUP_S = STARTUP_MIN_X10 * 60 / 10;
  localparam int HOUR_S = 3600;
  localparam int WEEK_H = 168;
  // ==========================================
  // register offsets and fields
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FA_OFF = 8'h04;
  localparam logic [7:0] REG_PW_OFF = 8'h08;
  localparam logic [7:0] REG_HS_OFF = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_SEL = 8'h14;
  localparam logic [7:0] REG_DET_INFO = 8'h18;
  localparam logic [7:0] REG_DET_LVL = 8'h1c;
  localparam logic [7:0] REG_REPLACE = 8'h20;
  localparam int CTRL_PW_EN_BIT = 0;
  localparam int CTRL_STEP_LSB = 8;
  // ==========================================
  // averaging sweep states
  typedef enum logic [2:0] {
    SW_IDLE = 3'b001,
    SW_RD = 3'b010,
    SW_UPD = 3'b100
  } sle_sweep_t;
endpackage

/* File: inc/sle_filt_if.sv */
// signals between the evaluator core and its decision filter
// assumes the filter is purely combinational
interface sle_filt_if;
  logic [7:0] smp;
  logic [7:0] dec;
  logic [7:0] step;
  logic [8:0] pw_lvl;
  logic [8:0] fa_lvl;
  logic [8:0] hs_lvl;
  logic [7:0] dec_nxt;
  logic pw_hit;
  logic fa_hit;
  logic hs_hit;
  modport user (output smp, dec, step, pw_lvl, fa_lvl, hs_lvl,
                input dec_nxt, pw_hit, fa_hit, hs_hit);
  modport filt (input smp, dec, step, pw_lvl, fa_lvl, hs_lvl,
                output dec_nxt, pw_hit, fa_hit, hs_hit);
endinterface

/* File: logic/sle_mem.sv */
// per-detector hourly sum store, one read and one write port
// assumes one clock; read data appear one cycle after rd_en_i
module sle_mem #(
  parameter int W = 16,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk_i,
  input wire logic rd_en_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [W-1:0] rd_data_o,
  input wire logic we_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [W-1:0] wr_data_i
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rd_en_i) begin
      rd_data_o <= mem[rd_addr_i];
    end
  end
endmodule // sle_mem

/* File: logic/sle_filt.sv */
// step filter for the decision value and level comparison
// assumes levels are already offset-added, 9 bits wide
module sle_filt (
  sle_filt_if.filt f
);
  logic up;
  logic [7:0] diff;

  always_comb begin
    up = f.smp > f.dec;
    diff = up ? f.smp - f.dec : f.dec - f.smp;
    if (diff <= f.step) begin
      f.dec_nxt = f.smp;
    end else if (up) begin
      f.dec_nxt = f.dec + f.step;
    end else begin
      f.dec_nxt = f.dec - f.step;
    end
  end

  assign f.pw_hit = {1'b0, f.dec_nxt} >= f.pw_lvl;
  assign f.fa_hit = {1'b0, f.dec_nxt} >= f.fa_lvl;
  assign f.hs_hit = {1'b0, f.dec_nxt} >= f.hs_lvl;
endmodule // sle_filt

/* File: tb/sle_chk.sv */
// checker for the smoke level evaluator top ports
// assumes one clock domain with a synchronous active-high reset
module sle_chk #(
  parameter int N_DET = 8,
  parameter int DIW = 3,
  parameter int SEC_CYC = 10,
  parameter int STARTUP_S = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic smp_valid_i,
  input wire logic [DIW-1:0] smp_det_i,
  input wire logic [N_DET-1:0] prewarn_o,
  input wire logic [N_DET-1:0] fire_o,
  input wire logic [N_DET-1:0] heavy_o,
  input wire logic [N_DET-1:0] service_o,
  input wire logic startup_done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import sle_pkg::*;
  // ======
  // helpers
  localparam longint LIM = longint'(STARTUP_S) * SEC_CYC + 2 * N_DET + 8;
  logic [63:0] cnt_r;
  logic pw_en_r;
  logic wr_any;
  logic wr_repl;
  assign wr_any = wb_cyc_i && wb_stb_i && wb_we_i;
  assign wr_repl = wr_any && wb_adr_i == REG_REPLACE;
  always_ff @(posedge clk_i) begin
    if (rst_i) cnt_r <= '0;
    else if (cnt_r < LIM) cnt_r <= cnt_r + 64'h1;
  end
  // tracks the prewarn enable as the bus takes it
  always_ff @(posedge clk_i) begin
    if (rst_i) pw_en_r <= PW_EN_RST;
    else if (wr_any && wb_ack_o && wb_adr_i == REG_CTRL && wb_sel_i[0])
      pw_en_r <= wb_dat_i[CTRL_PW_EN_BIT];
  end
  // ======
  // properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_ack_cause:
    assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
  a_req_answer:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_no_early_fire:
    assert property (!startup_done_o |-> fire_o == '0 && heavy_o == '0)
      else $error("alarm before first average");
  a_flags_hold:
    assert property (!smp_valid_i && !wr_any |=>
      $stable(prewarn_o) && $stable(fire_o) && $stable(heavy_o)) else $error("flag moved");
  a_start_kept:
    assert property (startup_done_o |=> startup_done_o) else $error("startup done fell");
  a_start_bound:
    assert property (cnt_r == LIM |-> startup_done_o) else $error("first average late");
  a_service_held:
    assert property (!wr_repl |=> (service_o & $past(service_o)) == $past(service_o))
      else $error("service dropped");
  a_prewarn_off:
    assert property (smp_valid_i && !pw_en_r && smp_det_i < N_DET |=>
      !prewarn_o[$past(smp_det_i)]) else $error("prewarn while disabled");
endmodule // sle_chk

bind sle_top sle_chk #(.N_DET(N_DET), .DIW(DIW), .SEC_CYC(SEC_CYC), .STARTUP_S(STARTUP_S))
  u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .smp_valid_i(smp_valid_i), .smp_det_i(smp_det_i),
  .prewarn_o(prewarn_o), .fire_o(fire_o), .heavy_o(heavy_o), .service_o(service_o),
  .startup_done_o(startup_done_o));

/* File: tb/sle_det_loop.sv */
// behavioural detector loop: hands over one sensor sample per poll
// assumes the caller lets poll return before calling it again
module sle_det_loop #(
  parameter int DIW = 3
) (
  input wire logic clk_i,
  output logic smp_valid_o,
  output logic [DIW-1:0] smp_det_o,
  output logic [7:0] smp_val_o
);
  timeunit 1ns;
  timeprecision 1ns;
  bit busy = 1'b0;
  initial begin
    smp_valid_o = 1'b0;
    smp_det_o = '0;
    smp_val_o = 8'h00;
  end
  // idle lines keep toggling between the last sample and its inverse
  always @(posedge clk_i) begin
    if (!busy) begin
      smp_det_o <= ~smp_det_o;
      smp_val_o <= ~smp_val_o;
    end
  end
  task automatic poll(input logic [DIW-1:0] det, input logic [7:0] val);
    busy = 1'b1;
    @(posedge clk_i);
    smp_valid_o <= 1'b1;
    smp_det_o <= det;
    smp_val_o <= val;
    @(posedge clk_i);
    smp_valid_o <= 1'b0;
    busy = 1'b0;
  endtask
endmodule // sle_det_loop

/* File: tb/sle_tb_top.sv */
// self-checking bench for the smoke level evaluator
// assumes shortened timing: 10 cycles a second, 3 s start, 4 s hour, 2 h week
module sle_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sle_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic smp_valid_i;
  logic [2:0] smp_det_i;
  logic [7:0] smp_val_i;
  logic [7:0] prewarn_o;
  logic [7:0] fire_o;
  logic [7:0] heavy_o;
  logic [7:0] service_o;
  logic startup_done_o;
  logic [31:0] q;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc_n = 0;
  logic [7:0] ra [5] = '{REG_CTRL, REG_FA_OFF, REG_PW_OFF, REG_HS_OFF, 8'h40};
  logic [31:0] rv [5] = '{32'h0a01, 32'h1e, 32'h16, 32'h32, 32'h0};
  logic [7:0] sv [9] = '{8'h0a, 8'h14, 8'h17, 8'h16, 8'h1f, 8'h29, 8'h32, 8'h33, 8'h00};
  logic [2:0] sf [9] = '{3'h0, 3'h0, 3'h1, 3'h0, 3'h3, 3'h3, 3'h3, 3'h7, 3'h3};

  always #25 clk_i = ~clk_i;

  sle_det_loop u_loop (.clk_i(clk_i), .smp_valid_o(smp_valid_i),
    .smp_det_o(smp_det_i), .smp_val_o(smp_val_i));

  sle_top #(.SEC_CYC(10), .STARTUP_S(3), .HOUR_S(4), .WEEK_H(2)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .smp_valid_i(smp_valid_i),
    .smp_det_i(smp_det_i), .smp_val_i(smp_val_i), .prewarn_o(prewarn_o), .fire_o(fire_o),
    .heavy_o(heavy_o), .service_o(service_o), .startup_done_o(startup_done_o));

  // ======
  // tasks
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // flags of one detector as {heavy, fire, prewarn}
  task automatic chk_flag(input int d, input logic [2:0] e);
    logic [2:0] g;
    @(negedge clk_i);
    g = {heavy_o[d], fire_o[d], prewarn_o[d]};
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value flags expected %h seen %h", e, g);
    end
  endtask
  task automatic wb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                         input logic [3:0] s, output logic [31:0] r);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wb_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb_xfer(a, 1'b1, d, 4'hf, r);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb_xfer(a, 1'b0, 32'h0, 4'hf, r);
    chk_reg(nm, e, r);
  endtask
  function automatic logic [31:0] lvl(input logic [8:0] a);
    return {5'h00, a + 9'(HS_OFF_RST), a + 9'(FA_OFF_RST), a + 9'(PW_OFF_RST)};
  endfunction

  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 1000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // ======
  // sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("det0 rst", REG_DET_INFO, 32'h0001_0001);
    repeat (5) u_loop.poll(3'h0, 8'hc8);
    chk_flag(0, 3'h1);
    u_loop.poll(3'h0, 8'h2d);
    u_loop.poll(3'h0, 8'h05);
    wb_wr(REG_SEL, 32'h0);
    rd_chk("det0 info", REG_DET_INFO, 32'h0101_2305);
    wb_wr(8'h40, 32'hffff_ffff);
    wb_xfer(REG_FA_OFF, 1'b1, 32'h0000_00ff, 4'he, q);
    for (int i = 0; i < 5; i++) begin
      rd_chk("config", ra[i], rv[i]);
    end
    for (int i = 0; i < 200 && startup_done_o !== 1'b1; i++) @(posedge clk_i);
    rd_chk("status", REG_STATUS, 32'h1);
    u_loop.poll(3'h2, 8'h1e);
    rd_chk("det0 lvl", REG_DET_LVL, lvl(9'h005));
    wb_wr(REG_SEL, 32'h1);
    rd_chk("det1 lvl", REG_DET_LVL, lvl(9'h001));
    for (int i = 0; i < 9; i++) begin
      u_loop.poll(3'h1, sv[i]);
      chk_flag(1, sf[i]);
    end
    wb_wr(REG_CTRL, 32'h0a00);
    u_loop.poll(3'h1, 8'h1f);
    chk_flag(1, 3'h2);
    wb_wr(REG_CTRL, 32'h0a01);
    for (int i = 0; i < 300 && service_o[2] !== 1'b1; i++) @(posedge clk_i);
    wb_wr(REG_SEL, 32'h2);
    wb_xfer(REG_DET_INFO, 1'b0, 32'h0, 4'hf, q);
    chk_reg("det2 avg", 32'h112, {23'h0, q[27], q[23:16]});
    rd_chk("det2 lvl", REG_DET_LVL, lvl(9'h012));
    wb_wr(REG_REPLACE, 32'h2);
    rd_chk("det2 info", REG_DET_INFO, 32'h0001_0001);
    chk_reg("service", 32'h0, {31'h0, service_o[2]});
    // restart in mid-run: the first average must come again
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk_reg("restart", 32'h0, {31'h0, startup_done_o});
    for (int i = 0; i < 200 && startup_done_o !== 1'b1; i++) @(posedge clk_i);
    chk_reg("restart done", 32'h1, {31'h0, startup_done_o});
    print_verdict();
  end
endmodule // sle_tb_top
